/* rtl/nv_access_regs.sv */
// register front end of the 1024 x 8 nonvolatile data store
// =====================================================
// Notes on behaviour
// (R01) store holds 1024 bytes, byte addressed
// (R02) store reachable only through these registers
// (R03) single-byte transfers via address, data, control
// (R04) address and data registers directly read/write
// (R05) control at 40h sector 1, indirect only
// (R06) software points a pointer pair at 0140h
// (R07) low address byte read/write, resets zero
// (R08) high address keeps bits 9:8, resets zero
// (R09) high address upper bits read zero
// (R10) data register read/write byte, resets zero
// (R11) time select picks erase/write durations
// (R12) erase start ignored unless erase enabled
// (R13) address is high bits over low byte
`timescale 1ns/1ns
`default_nettype none
module nv_access_regs #(
   parameter int ERASE_SHORT_US = nv_pkg::ERASE_SHORT_US,
   parameter int ERASE_LONG_US = nv_pkg::ERASE_LONG_US,
   parameter int WRITE_SHORT_US = nv_pkg::WRITE_SHORT_US,
   parameter int WRITE_LONG_US = nv_pkg::WRITE_LONG_US
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // sector 0 special function register port
   input wire logic [nv_pkg::SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [nv_pkg::DATA_W-1:0] sfr_wdata,
   output logic [nv_pkg::DATA_W-1:0] sfr_rdata,
   // status
   output logic nv_busy
);
   import nv_pkg::*;

   localparam int TMAX = 2 ** TIME_W;

   if (ERASE_SHORT_US < 1 || ERASE_SHORT_US >= TMAX ||
       ERASE_LONG_US < 1 || ERASE_LONG_US >= TMAX ||
       WRITE_SHORT_US < 1 || WRITE_SHORT_US >= TMAX ||
       WRITE_LONG_US < 1 || WRITE_LONG_US >= TMAX) begin : g_chk
      $error("program times must fit the timer width");
   end

   localparam logic [TIME_W-1:0] ER_S = TIME_W'(ERASE_SHORT_US);
   localparam logic [TIME_W-1:0] ER_L = TIME_W'(ERASE_LONG_US);
   localparam logic [TIME_W-1:0] WR_S = TIME_W'(WRITE_SHORT_US);
   localparam logic [TIME_W-1:0] WR_L = TIME_W'(WRITE_LONG_US);

   // true when a pointer pair addresses the control register
   function automatic logic ptr_hits_ctl(input logic [7:0] lo,
                                         input logic [7:0] hi);
      return hi == CTL_SECTOR && lo == CTL_OFFSET;
   endfunction

   // =====================================================
   // state
   logic [ADDR_LO_W-1:0] lo_q;
   logic [ADDR_HI_W-1:0] hi_q;
   logic [DATA_W-1:0] data_q, data_d;
   logic [7:0] p1l_q, p1h_q, p2l_q, p2h_q;
   logic [7:0] ctl_q, ctl_d;
   logic [DATA_W-1:0] rdata_q;
   logic busy_q;
   nv_state_t state_q, state_d;

   // =====================================================
   // address decode
   wire sel_lo = sfr_addr == OFF_ADDR_LO;
   wire sel_hi = sfr_addr == OFF_ADDR_HI;
   wire sel_data = sfr_addr == OFF_DATA;
   wire sel_p1l = sfr_addr == OFF_PTR1_LO;
   wire sel_p1h = sfr_addr == OFF_PTR1_HI;
   wire sel_p2l = sfr_addr == OFF_PTR2_LO;
   wire sel_p2h = sfr_addr == OFF_PTR2_HI;
   wire sel_ip1 = sfr_addr == OFF_PORT_ONE;
   wire sel_ip2 = sfr_addr == OFF_PORT_TWO;

   // control is seen only through an indirect port whose pointer
   // pair holds sector 1, offset 40h
   wire ctl_via1 = sel_ip1 && ptr_hits_ctl(p1l_q, p1h_q); // [R05] [R06]
   wire ctl_via2 = sel_ip2 && ptr_hits_ctl(p2l_q, p2h_q); // [R05] [R06]
   wire ctl_sel = ctl_via1 || ctl_via2;
   wire ctl_wr = sfr_wr && ctl_sel;

   wire idle = state_q == ST_IDLE;
   wire [DATA_W-1:0] hi_rd = {{(DATA_W-ADDR_HI_W){1'b0}}, hi_q}; // [R09]

   // store has no address of its own; every path goes via these
   wire [DATA_W-1:0] rd_mux = // [R02] [R04]
      sel_lo ? lo_q :
      sel_hi ? hi_rd :
      sel_data ? data_q :
      sel_p1l ? p1l_q :
      sel_p1h ? p1h_q :
      sel_p2l ? p2l_q :
      sel_p2h ? p2h_q :
      ctl_sel ? ctl_q : 8'h00;

   // =====================================================
   // store and timer hookup
   wire tmr_done;
   wire erase_fin = state_q == ST_ERASE && tmr_done;
   wire write_fin = state_q == ST_WRITE && tmr_done;
   wire read_fin = state_q == ST_READ_WAIT;
   wire st_we = erase_fin || write_fin; // [R03]
   wire st_en = st_we || state_q == ST_READ;
   wire [ADDR_W-1:0] st_addr = {hi_q, lo_q}; // [R13]
   wire [DATA_W-1:0] st_wdata = erase_fin ? ERASED_BYTE : data_q;
   wire [DATA_W-1:0] st_rdata;

   wire tmr_start = idle && (ctl_q[BIT_ER] || ctl_q[BIT_WR]);
   wire tsel = ctl_q[BIT_TSEL];
   wire [TIME_W-1:0] tmr_dur = // [R11]
      ctl_q[BIT_ER] ? (tsel ? ER_L : ER_S) : (tsel ? WR_L : WR_S);

   nv_store u_store (
      .clk(clk),
      .en(st_en),
      .we(st_we),
      .addr(st_addr),
      .wdata(st_wdata),
      .rdata_q(st_rdata)
   );

   program_timer u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(tmr_start),
      .duration_us(tmr_dur),
      .done(tmr_done)
   );

   // =====================================================
   // sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (ctl_q[BIT_ER]) begin
               state_d = ST_ERASE;
            end else if (ctl_q[BIT_WR]) begin
               state_d = ST_WRITE;
            end else if (ctl_q[BIT_RD]) begin
               state_d = ST_READ;
            end
         end
         ST_ERASE: begin
            if (tmr_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (tmr_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_READ: state_d = ST_READ_WAIT;
         ST_READ_WAIT: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // =====================================================
   // control register next value
   always_comb begin
      ctl_d = ctl_q;
      if (erase_fin) begin
         ctl_d[BIT_ER] = 1'b0;
         ctl_d[BIT_ERASE_ENABLE] = 1'b0;
      end
      if (write_fin) begin
         ctl_d[BIT_WR] = 1'b0;
         ctl_d[BIT_WRITE_ENABLE] = 1'b0;
      end
      if (read_fin) begin
         ctl_d[BIT_RD] = 1'b0;
      end
      // software write wins over a same-cycle hardware clear of the enable bits; start bits still clear
      if (ctl_wr) begin
         ctl_d[BIT_TSEL] = sfr_wdata[BIT_TSEL];
         ctl_d[BIT_ERASE_ENABLE] = sfr_wdata[BIT_ERASE_ENABLE];
         ctl_d[BIT_PAGE] = sfr_wdata[BIT_PAGE];
         ctl_d[BIT_WRITE_ENABLE] = sfr_wdata[BIT_WRITE_ENABLE];
         ctl_d[BIT_READ_ENABLE] = sfr_wdata[BIT_READ_ENABLE];
         if (idle) begin
            ctl_d[BIT_ER] = sfr_wdata[BIT_ER] && ctl_q[BIT_ERASE_ENABLE]; // [R12]
            ctl_d[BIT_WR] = sfr_wdata[BIT_WR] && ctl_q[BIT_WRITE_ENABLE];
            ctl_d[BIT_RD] = sfr_wdata[BIT_RD] && ctl_q[BIT_READ_ENABLE];
         end
      end
   end

   // read completion has priority over a software write
   always_comb begin
      data_d = data_q;
      if (read_fin) begin
         data_d = st_rdata; // [R03]
      end else if (sfr_wr && sel_data) begin
         data_d = sfr_wdata; // [R10]
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lo_q <= ADDR_LO_RST; // [R07]
         hi_q <= ADDR_HI_RST; // [R08]
         data_q <= DATA_RST; // [R10]
         ctl_q <= CTL_RST;
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
      end else begin
         if (sfr_wr && sel_lo) begin
            lo_q <= sfr_wdata; // [R07]
         end
         if (sfr_wr && sel_hi) begin
            hi_q <= sfr_wdata[ADDR_HI_W-1:0]; // [R08]
         end
         data_q <= data_d;
         ctl_q <= ctl_d;
         state_q <= state_d;
         busy_q <= state_d != ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         p1l_q <= PTR_RST;
         p1h_q <= PTR_RST;
         p2l_q <= PTR_RST;
         p2h_q <= PTR_RST;
         rdata_q <= 8'h00;
      end else begin
         if (sfr_wr && sel_p1l) p1l_q <= sfr_wdata;
         if (sfr_wr && sel_p1h) p1h_q <= sfr_wdata;
         if (sfr_wr && sel_p2l) p2l_q <= sfr_wdata;
         if (sfr_wr && sel_p2h) p2h_q <= sfr_wdata;
         if (sfr_rd) rdata_q <= rd_mux; // [R04]
      end
   end

   assign sfr_rdata = rdata_q;
   assign nv_busy = busy_q;

   // =====================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   erase_gate_a: assert property ( // [R12]
      ctl_wr && sfr_wdata[BIT_ER] && !ctl_q[BIT_ERASE_ENABLE] && !ctl_q[BIT_ER]
      |=> !ctl_q[BIT_ER] ##1 state_q != ST_ERASE)
      else $error("erase started without erase enable");

   high_addr_zero_a: assert property ( // [R09]
      sfr_rd && sel_hi |=> sfr_rdata[7:ADDR_HI_W] == '0)
      else $error("unused high address bits read nonzero");

   high_addr_keep_a: assert property ( // [R08]
      sfr_wr && sel_hi
      |=> hi_q == $past(sfr_wdata[ADDR_HI_W-1:0]))
      else $error("high address bits not retained");

   low_addr_a: assert property ( // [R07]
      sfr_wr && sel_lo |=> lo_q == $past(sfr_wdata))
      else $error("low address write lost");

   addr_join_a: assert property ( // [R13]
      st_en |-> st_addr ==
                ((ADDR_W'(hi_q) << ADDR_LO_W) | ADDR_W'(lo_q)))
      else $error("store address not formed from both registers");

   data_wr_a: assert property ( // [R10]
      sfr_wr && sel_data && !read_fin |=> data_q == $past(sfr_wdata))
      else $error("data register write lost");

   data_readback_a: assert property ( // [R04]
      sfr_rd && sel_data && !read_fin |=> sfr_rdata == $past(data_q))
      else $error("data register read back wrong");

   ctl_indirect_a: assert property ( // [R05]
      sfr_wr && sel_ip1 && ptr_hits_ctl(p1l_q, p1h_q)
      |=> ctl_q[BIT_TSEL] == $past(sfr_wdata[BIT_TSEL]))
      else $error("control not written through indirect port");

   ctl_hidden_a: assert property ( // [R05]
      sfr_rd && (sel_ip1 || sel_ip2) && !ctl_sel |=> sfr_rdata == 8'h00)
      else $error("control visible without matching pointer");

   time_select_a: assert property ( // [R11]
      tmr_start && ctl_q[BIT_ER]
      |=> u_timer.left_q == ($past(ctl_q[BIT_TSEL]) ? ER_L : ER_S))
      else $error("erase duration does not follow time select");

   read_load_a: assert property ( // [R03]
      idle && ctl_q[BIT_RD] && !ctl_q[BIT_ER] && !ctl_q[BIT_WR]
      |=> state_q == ST_READ ##1 read_fin
      ##1 data_q == $past(st_rdata) && !ctl_q[BIT_RD])
      else $error("read did not load one byte into data");

endmodule
`default_nettype wire

/* rtl/nv_pkg.sv */
// shared constants and types for the nonvolatile byte store front end
package nv_pkg;

   // =====================================================
   // store geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1024;
   localparam int ADDR_LO_W = 8;
   localparam int ADDR_HI_W = ADDR_W - ADDR_LO_W;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // =====================================================
   // sector 0 special function register offsets
   localparam int SFR_AW = 8;
   localparam logic [7:0] OFF_PORT_ONE = 8'h00;
   localparam logic [7:0] OFF_PTR1_LO = 8'h01;
   localparam logic [7:0] OFF_PTR1_HI = 8'h02;
   localparam logic [7:0] OFF_PORT_TWO = 8'h03;
   localparam logic [7:0] OFF_PTR2_LO = 8'h04;
   localparam logic [7:0] OFF_PTR2_HI = 8'h05;
   localparam logic [7:0] OFF_ADDR_LO = 8'h2c;
   localparam logic [7:0] OFF_ADDR_HI = 8'h2d;
   localparam logic [7:0] OFF_DATA = 8'h2e;

   // control register location, reached indirectly
   localparam logic [7:0] CTL_SECTOR = 8'h01;
   localparam logic [7:0] CTL_OFFSET = 8'h40;

   // =====================================================
   // control register fields
   localparam int BIT_TSEL = 7;
   localparam int BIT_ERASE_ENABLE = 6;
   localparam int BIT_ER = 5;
   localparam int BIT_PAGE = 4;
   localparam int BIT_WRITE_ENABLE = 3;
   localparam int BIT_WR = 2;
   localparam int BIT_READ_ENABLE = 1;
   localparam int BIT_RD = 0;

   // =====================================================
   // reset values
   localparam logic [7:0] ADDR_LO_RST = 8'h00;
   localparam logic [1:0] ADDR_HI_RST = 2'h0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] PTR_RST = 8'h00;

   // =====================================================
   // timing: microsecond tick from the 8 ns clock
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIME_W = 12;
   localparam real ERASE_SHORT_MS = 3.2;
   localparam real WRITE_SHORT_MS = 2.2;
   localparam real ERASE_LONG_MS = 3.7;
   localparam real WRITE_LONG_MS = 3.0;
   localparam int ERASE_SHORT_US = int'($ceil(ERASE_SHORT_MS * 1000.0));
   localparam int WRITE_SHORT_US = int'($ceil(WRITE_SHORT_MS * 1000.0));
   localparam int ERASE_LONG_US = int'($ceil(ERASE_LONG_MS * 1000.0));
   localparam int WRITE_LONG_US = int'($ceil(WRITE_LONG_MS * 1000.0));

   typedef enum logic [2:0] {
      ST_IDLE, ST_ERASE, ST_WRITE, ST_READ, ST_READ_WAIT
   } nv_state_t;

endpackage

/* rtl/nv_store.sv */
// byte-wide storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module nv_store #(
   parameter int WIDTH = nv_pkg::DATA_W,
   parameter int DEPTH = nv_pkg::DEPTH,
   parameter int AW = nv_pkg::ADDR_W
) (
   // clock
   input wire logic clk,
   // access port
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata_q
);

   if (DEPTH > 2 ** AW || WIDTH < 1) begin : g_chk
      $error("store depth exceeds address range");
   end

   // =====================================================
   // array: one byte per location
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin // [R01]
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en && !we) begin
         rdata_q <= mem[addr];
      end
   end

endmodule
`default_nettype wire

/* rtl/program_timer.sv */
// microsecond divider and down counter for erase and write cycles
`timescale 1ns/1ns
`default_nettype none
module program_timer #(
   parameter int TICK = nv_pkg::TICK_CYCLES,
   parameter int TIME_W = nv_pkg::TIME_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // request
   input wire logic start,
   input wire logic [TIME_W-1:0] duration_us,
   // completion pulse
   output logic done
);

   localparam int DIV_W = $clog2(TICK);

   if (TICK < 2 || TIME_W < 2) begin : g_chk
      $error("timer tick or width too small");
   end

   // =====================================================
   // divider and count
   logic [DIV_W-1:0] div_q;
   logic [TIME_W-1:0] left_q;
   logic run_q;
   logic done_q;

   wire tick = run_q && div_q == DIV_W'(TICK - 1);
   wire last = tick && left_q == TIME_W'(1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_q <= '0;
         left_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= last;
         if (start) begin
            div_q <= '0;
            left_q <= duration_us;
            run_q <= 1'b1;
         end else if (tick) begin
            div_q <= '0;
            left_q <= left_q - TIME_W'(1);
            run_q <= !last;
         end else if (run_q) begin
            div_q <= div_q + DIV_W'(1);
         end
      end
   end

   assign done = done_q;

endmodule
`default_nettype wire

/* tb/test_eeprom_address_data_registers.sv */
// self-checking bench for the nonvolatile store register front end
`timescale 1ns/1ns
`default_nettype none
module test_eeprom_address_data_registers;
   import nv_pkg::*;

   // =====================================================
   // design hookup
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic nv_busy;
   int bad_count = 0;
   int tests_run = 0;
   int ew0, ew1, ee0, ee1;

   nv_access_regs #(
      .ERASE_SHORT_US(2),
      .ERASE_LONG_US(3),
      .WRITE_SHORT_US(2),
      .WRITE_LONG_US(3)
   ) dut (
      .clk(clk),
      .sys_rst(sys_rst),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .nv_busy(nv_busy)
   );

   always #4 clk = ~clk;

   // =====================================================
   // access tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk);
      #1;
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge clk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk);
      #1;
      sfr_rd = 1'b0;
      chk(what, exp, sfr_rdata);
   endtask

   // control register through pointer pair one
   task automatic ctl_wr(input logic [7:0] d);
      wr(OFF_PTR1_LO, CTL_OFFSET);
      wr(OFF_PTR1_HI, CTL_SECTOR);
      wr(OFF_PORT_ONE, d);
   endtask

   task automatic ctl_rd(input logic [7:0] exp);
      wr(OFF_PTR1_LO, CTL_OFFSET);
      wr(OFF_PTR1_HI, CTL_SECTOR);
      rd(OFF_PORT_ONE, exp, "control");
   endtask

   // counts busy cycles; bounded wait
   task automatic wait_idle(output int n);
      n = 0;
      // busy rises one edge after the start bit lands
      @(posedge clk);
      #1;
      tests_run++;
      if (nv_busy !== 1'b1) begin
         bad_count++;
         $display("[ERR] busy expected 1 seen %b", nv_busy);
      end
      while (nv_busy === 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         $display("[ERR] busy_timeout expected 0 seen 1");
         summarize();
      end
   endtask

   task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
      wr(OFF_ADDR_HI, hi);
      wr(OFF_ADDR_LO, lo);
   endtask

   task automatic nv_read(input logic [7:0] hi, input logic [7:0] lo,
                          input logic [7:0] exp);
      int n;
      set_addr(hi, lo);
      ctl_wr(8'h82);
      ctl_wr(8'h83);
      wait_idle(n);
      rd(OFF_DATA, exp, "read_byte");
   endtask

   // =====================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      rd(OFF_ADDR_LO, 8'h00, "addr_lo_reset");
      rd(OFF_ADDR_HI, 8'h00, "addr_hi_reset");
      rd(OFF_DATA, 8'h00, "data_reset");
      ctl_rd(8'h00);
      wr(OFF_ADDR_LO, 8'h5a);
      rd(OFF_ADDR_LO, 8'h5a, "addr_lo");
      wr(OFF_ADDR_HI, 8'hff);
      rd(OFF_ADDR_HI, 8'h03, "addr_hi_masked");
      wr(OFF_DATA, 8'ha5);
      rd(OFF_DATA, 8'ha5, "data");
      wr(8'h10, 8'h77);
      rd(8'h10, 8'h00, "unmapped");
      // wrong pointer high byte: control must stay out of reach
      wr(OFF_PTR1_LO, CTL_OFFSET);
      wr(OFF_PTR1_HI, 8'h00);
      wr(OFF_PORT_ONE, 8'h88);
      rd(OFF_PORT_ONE, 8'h00, "port_wrong_ptr");
      wr(OFF_PTR2_LO, CTL_OFFSET);
      wr(OFF_PTR2_HI, CTL_SECTOR);
      rd(OFF_PORT_TWO, 8'h00, "control_port_two");
      wr(OFF_PORT_TWO, 8'h10);
      ctl_rd(8'h10);
      ctl_wr(8'h20);
      ctl_rd(8'h00);
      ctl_wr(8'h60);
      ctl_rd(8'h40);
      ctl_wr(8'h00);
      // two byte writes differing only in bit 8 of the address
      set_addr(8'h01, 8'h23);
      wr(OFF_DATA, 8'h3c);
      ctl_wr(8'h08);
      ctl_wr(8'h0c);
      wait_idle(ew0);
      ctl_rd(8'h00);
      tests_run++;
      // short write of 2 units: busy for 2 ticks plus the store edge
      if (ew0 != 2 * TICK_CYCLES + 1) begin
         bad_count++;
         $display("[ERR] write_time expected %0d seen %0d",
                  2 * TICK_CYCLES + 1, ew0);
      end
      set_addr(8'h00, 8'h23);
      wr(OFF_DATA, 8'hc3);
      ctl_wr(8'h88);
      ctl_wr(8'h8c);
      wait_idle(ew1);
      ctl_rd(8'h80);
      tests_run++;
      if (ew1 - ew0 != TICK_CYCLES) begin
         bad_count++;
         $display("[ERR] write_time_delta expected %0d seen %0d",
                  TICK_CYCLES, ew1 - ew0);
      end
      nv_read(8'h01, 8'h23, 8'h3c);
      nv_read(8'h00, 8'h23, 8'hc3);
      // erase both bytes with long then short timing
      set_addr(8'h01, 8'h23);
      ctl_wr(8'hc0);
      ctl_wr(8'he0);
      wait_idle(ee1);
      set_addr(8'h00, 8'h23);
      ctl_wr(8'h40);
      ctl_wr(8'h60);
      wait_idle(ee0);
      tests_run++;
      if (ee1 - ee0 != TICK_CYCLES) begin
         bad_count++;
         $display("[ERR] erase_time_delta expected %0d seen %0d",
                  TICK_CYCLES, ee1 - ee0);
      end
      nv_read(8'h01, 8'h23, ERASED_BYTE);
      nv_read(8'h00, 8'h23, ERASED_BYTE);
      summarize();
   end
endmodule
`default_nettype wire
